//--- rtl/chop_pkg.sv
// constants for the constant off-time chopper and protection logic
// assumes one system clock; analog comparators arrive already synchronous
package chop_pkg;
	localparam int TIMER_W = 10;
	// fast decay length per step of the setting, in clocks
	localparam logic [TIMER_W-1:0] FAST_UNIT = 10'h020;
	// slow decay length: setting times unit plus base, in clocks
	localparam logic [TIMER_W-1:0] SLOW_UNIT = 10'h020;
	localparam logic [TIMER_W-1:0] SLOW_BASE = 10'h018;
	localparam int RND_BITS = 3;
	localparam logic [3:0] OFFSET_ZERO = 4'h3;
	localparam logic [1:0] SHORT_RETRIES = 2'h3;
	localparam logic [15:0] LFSR_SEED = 16'hACE1;
	localparam logic [3:0] STATUS_RESET = 4'h0;
	localparam int ST_OT = 0;
	localparam int ST_PREWARN = 1;
	localparam int ST_SHORT_A = 2;
	localparam int ST_SHORT_B = 3;
endpackage : chop_pkg

//--- rtl/coil_chopper.sv
// one coil's constant off-time chopper and sine offset correction
// assumes comparator inputs are synchronous and the bridge enable is decided upstream
`timescale 1ns/10ps
module coil_chopper import chop_pkg::*; #(
	parameter int RND_W = RND_BITS
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic run,
	input wire logic const_mode,
	input wire logic on_trip,
	input wire logic fd_comp,
	input wire logic fd_comp_off,
	input wire logic [3:0] fast_decay_time,
	input wire logic [3:0] slow_decay_time,
	input wire logic rnd_en,
	input wire logic [RND_W-1:0] rnd,
	input wire logic [7:0] target,
	input wire logic [3:0] offset_field,
	output logic phase_on,
	output logic phase_fast,
	output logic phase_slow,
	output logic [7:0] target_out
);
	typedef enum logic [1:0] {ST_IDLE, ST_ON, ST_FAST, ST_SLOW} chop_state_t;
	chop_state_t state_reg, state_next;
	logic [TIMER_W-1:0] timer_reg, timer_next;
	logic [RND_W-1:0] rnd_reg, rnd_next;
	logic [7:0] target_reg, target_next;
	logic [TIMER_W-1:0] fast_len, slow_len;
	logic active;
	logic signed [9:0] corr;

	assign active = run && const_mode && (slow_decay_time != 4'h0);
	assign fast_len = TIMER_W'(fast_decay_time) * FAST_UNIT; // see RL3
	// random spread is added, never subtracted, so the off time never falls below the setting
	assign slow_len = TIMER_W'(slow_decay_time) * SLOW_UNIT + SLOW_BASE + TIMER_W'(rnd_reg);

	always_comb begin
		state_next = state_reg;
		timer_next = timer_reg;
		rnd_next = rnd_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (active) begin
					state_next = ST_ON;
				end
			end
			ST_ON: begin
				timer_next = '0;
				if (on_trip) begin
					// zero setting skips fast decay
					state_next = (fast_decay_time != 4'h0) ? ST_FAST : ST_SLOW; // see RL1 see RL3
					rnd_next = rnd_en ? rnd : '0; // see RL8
				end
			end
			ST_FAST: begin
				timer_next = timer_reg + 1'b1;
				if ((fd_comp && !fd_comp_off) || timer_reg >= fast_len - 1'b1) begin // see RL6
					state_next = ST_SLOW;
					timer_next = '0;
				end
			end
			ST_SLOW: begin
				timer_next = timer_reg + 1'b1;
				if (timer_reg >= slow_len - 1'b1) begin
					state_next = ST_ON;
				end
			end
		endcase
		if (!active) begin
			state_next = ST_IDLE;
			timer_next = '0;
		end
	end

	always_comb begin
		corr = $signed({2'b00, target}) + $signed({6'h00, offset_field})
			- $signed({6'h00, OFFSET_ZERO}); // see RL4
		if (!const_mode) begin
			target_next = target; // see RL5
		end else if (corr < 0) begin
			target_next = 8'h00;
		end else if (corr > 10'sh0FF) begin
			target_next = 8'hFF;
		end else begin
			target_next = corr[7:0];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			timer_reg <= '0;
			rnd_reg <= '0;
			target_reg <= 8'h00;
		end else if (ce) begin
			state_reg <= state_next;
			timer_reg <= timer_next;
			rnd_reg <= rnd_next;
			target_reg <= target_next;
		end
	end

	assign phase_on = (state_reg == ST_ON);
	assign phase_fast = (state_reg == ST_FAST);
	assign phase_slow = (state_reg == ST_SLOW);
	assign target_out = target_reg;

	chk_trip_to_fast: assert property (@(posedge clk) disable iff (rst) // see RL1
		(ce && active && phase_on && on_trip && fast_decay_time != 4'h0) |=> phase_fast)
		else $error("trip did not start fast decay");
	chk_zero_slow_only: assert property (@(posedge clk) disable iff (rst) // see RL3
		(ce && active && phase_on && on_trip && fast_decay_time == 4'h0) |=> phase_slow)
		else $error("zero setting still used fast decay");
	chk_fast_by_time: assert property (@(posedge clk) disable iff (rst) // see RL6
		(ce && active && phase_fast && fd_comp_off && timer_reg < fast_len - 1'b1) |=> phase_fast)
		else $error("fast decay ended early with comparator off");
	chk_fast_by_comp: assert property (@(posedge clk) disable iff (rst) // see RL6
		(ce && active && phase_fast && fd_comp && !fd_comp_off) |=> phase_slow)
		else $error("comparator did not end fast decay");
	chk_offset_zero: assert property (@(posedge clk) disable iff (rst) // see RL4
		(ce && const_mode && offset_field == OFFSET_ZERO) |=> target_out == $past(target))
		else $error("offset three changed the target");
	chk_rnd_off: assert property (@(posedge clk) disable iff (rst) // see RL8
		(ce && phase_on && on_trip && !rnd_en) |=> rnd_reg == '0)
		else $error("random spread applied while disabled");
	cov_fast_cycle: cover property (@(posedge clk) disable iff (rst)
		phase_on ##1 phase_fast [*2] ##[1:600] phase_slow ##[1:600] phase_on);
	cov_comp_end: cover property (@(posedge clk) disable iff (rst)
		phase_fast && fd_comp && !fd_comp_off);
endmodule : coil_chopper

//--- rtl/motor_chopper_diag.sv
// two-coil constant off-time chopper with thermal and short-to-ground protection
// assumes analog comparator and short detector levels are synchronous to clk
`timescale 1ns/10ps
// Behaviour
// RL1 - on phase ends at comparator trip, then a configured fast decay follows
// RL2 - full-step in load-dependent speed mode forces constant off-time chopper
// RL3 - fast decay setting zero means slow decay only, else length proportional
// RL4 - offset field 0..2 negative, 3 none, 4..15 positive, added to target
// RL5 - fast decay and offset meanings apply only with chopper select set; the code also applies them in full-step speed mode with select clear
// RL6 - comparator ends fast decay early unless disabled, then time only
// RL7 - both coil choppers run independently with no synchronisation
// RL8 - random bit modulates slow decay time from a pseudo-random polynomial
// RL9 - prewarning flag and thermal shutdown flag, shutdown switches driver off
// RL10 - after shutdown driver stays off until temperature falls below prewarning
// RL11 - short-to-ground confirmed only after three retries, then bridge off
// RL12 - confirmed short disables only its own bridge and sets its own flag
// RL13 - short shutdown latches until driver is disabled then re-enabled
// RL14 - thermal, prewarning and per-coil short flags readable in status word
module motor_chopper_diag import chop_pkg::*; #(
	parameter int RND_W = RND_BITS
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic driver_enable,
	input wire logic chopper_select,
	input wire logic fullstep_mode,
	input wire logic speed_ctrl_mode,
	input wire logic fast_decay_msb,
	input wire logic [2:0] fast_decay_low_bits,
	input wire logic [3:0] sine_offset_field,
	input wire logic [3:0] slow_decay_time,
	input wire logic fd_comp_disable,
	input wire logic random_off_time,
	input wire logic [1:0] coil_on_trip,
	input wire logic [1:0] coil_fd_comp,
	input wire logic [1:0] coil_short_detect,
	input wire logic [7:0] coil_a_target,
	input wire logic [7:0] coil_b_target,
	input wire logic temp_prewarn,
	input wire logic temp_shutdown,
	output logic const_off_active,
	output logic [1:0] coil_phase_on,
	output logic [1:0] coil_phase_fast,
	output logic [1:0] coil_phase_slow,
	output logic [7:0] coil_a_target_out,
	output logic [7:0] coil_b_target_out,
	output logic [1:0] bridge_enable,
	output logic prewarn_flag,
	output logic thermal_shutdown_flag,
	output logic coil_a_ground_short_flag,
	output logic coil_b_ground_short_flag,
	output logic [3:0] driver_state_word
);
	logic [3:0] fast_decay_time;
	logic [15:0] lfsr_reg, lfsr_next;
	logic ot_reg, ot_next;
	logic pw_reg, pw_next;
	logic [1:0] short_flag_reg, short_flag_next;
	logic [1:0] retry_reg [2];
	logic [1:0] retry_next [2];
	logic [3:0] status_reg, status_next;
	logic [7:0] tgt_in [2];
	logic [7:0] tgt_out [2];
	logic [RND_W-1:0] rnd_pick [2];

	assign fast_decay_time = {fast_decay_msb, fast_decay_low_bits};
	assign const_off_active = chopper_select || (fullstep_mode && speed_ctrl_mode); // see RL2 see RL5
	assign tgt_in[0] = coil_a_target;
	assign tgt_in[1] = coil_b_target;
	assign coil_a_target_out = tgt_out[0];
	assign coil_b_target_out = tgt_out[1];
	// disjoint lfsr slices keep the two coils' off times decorrelated
	assign rnd_pick[0] = lfsr_reg[RND_W-1:0];
	assign rnd_pick[1] = lfsr_reg[8+RND_W-1:8];

	always_comb begin
		lfsr_next = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]}; // see RL8
		pw_next = temp_prewarn; // see RL9
		ot_next = ot_reg;
		if (!temp_prewarn) begin
			ot_next = 1'b0; // see RL10
		end
		if (temp_shutdown) begin
			ot_next = 1'b1; // see RL9
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_coil
			// each coil owns its state machine; nothing ties their cycles together
			coil_chopper #(.RND_W(RND_W)) u_chop ( // see RL7
				.clk(clk),
				.rst(rst),
				.ce(ce),
				.run(bridge_enable[gi]),
				.const_mode(const_off_active),
				.on_trip(coil_on_trip[gi]),
				.fd_comp(coil_fd_comp[gi]),
				.fd_comp_off(fd_comp_disable),
				.fast_decay_time(fast_decay_time),
				.slow_decay_time(slow_decay_time),
				.rnd_en(random_off_time),
				.rnd(rnd_pick[gi]),
				.target(tgt_in[gi]),
				.offset_field(sine_offset_field),
				.phase_on(coil_phase_on[gi]),
				.phase_fast(coil_phase_fast[gi]),
				.phase_slow(coil_phase_slow[gi]),
				.target_out(tgt_out[gi])
			);

			always_comb begin
				retry_next[gi] = retry_reg[gi];
				short_flag_next[gi] = short_flag_reg[gi];
				if (!driver_enable) begin
					short_flag_next[gi] = 1'b0; // see RL13
					retry_next[gi] = 2'h0;
				end else if (coil_on_trip[gi] && !coil_short_detect[gi]) begin
					// a clean on phase means the earlier hit was spurious
					retry_next[gi] = 2'h0;
				end
				if (coil_short_detect[gi] && bridge_enable[gi]) begin
					if (retry_reg[gi] == SHORT_RETRIES) begin
						short_flag_next[gi] = 1'b1; // see RL11 see RL12
					end else begin
						retry_next[gi] = retry_reg[gi] + 2'h1; // see RL11
					end
				end
			end

			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					retry_reg[gi] <= 2'h0;
					short_flag_reg[gi] <= 1'b0;
				end else if (ce) begin
					retry_reg[gi] <= retry_next[gi];
					short_flag_reg[gi] <= short_flag_next[gi];
				end
			end

			// only the shorted bridge drops; the other coil keeps running
			assign bridge_enable[gi] = driver_enable && !ot_reg && !short_flag_reg[gi]; // see RL12
		end
	endgenerate

	always_comb begin
		status_next = STATUS_RESET;
		status_next[ST_OT] = ot_next; // see RL14
		status_next[ST_PREWARN] = pw_next;
		status_next[ST_SHORT_A] = short_flag_next[0];
		status_next[ST_SHORT_B] = short_flag_next[1];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lfsr_reg <= LFSR_SEED;
			ot_reg <= 1'b0;
			pw_reg <= 1'b0;
			status_reg <= STATUS_RESET;
		end else if (ce) begin
			lfsr_reg <= lfsr_next;
			ot_reg <= ot_next;
			pw_reg <= pw_next;
			status_reg <= status_next;
		end
	end

	assign thermal_shutdown_flag = ot_reg;
	assign prewarn_flag = pw_reg;
	assign coil_a_ground_short_flag = short_flag_reg[0];
	assign coil_b_ground_short_flag = short_flag_reg[1];
	assign driver_state_word = status_reg;

	// an idle coil must start chopping once full-step speed mode is on, select bit or not
	chk_auto_select: assert property (@(posedge clk) disable iff (rst) // see RL2
		(ce && fullstep_mode && speed_ctrl_mode && bridge_enable[0] && slow_decay_time != 4'h0
			&& !coil_phase_on[0] && !coil_phase_fast[0] && !coil_phase_slow[0])
			|=> coil_phase_on[0])
		else $error("full-step speed mode did not start the chopper");
	chk_ot_bridge_off: assert property (@(posedge clk) disable iff (rst) // see RL9
		(ce && temp_shutdown) |=> (thermal_shutdown_flag && bridge_enable == 2'b00))
		else $error("shutdown did not switch bridges off");
	chk_ot_hold: assert property (@(posedge clk) disable iff (rst) // see RL10
		(ce && thermal_shutdown_flag && temp_prewarn) |=> thermal_shutdown_flag)
		else $error("thermal shutdown released above prewarning");
	chk_ot_release: assert property (@(posedge clk) disable iff (rst) // see RL10
		(ce && !temp_prewarn && !temp_shutdown) |=> !thermal_shutdown_flag)
		else $error("thermal shutdown did not release");
	chk_short_retry: assert property (@(posedge clk) disable iff (rst) // see RL11
		(ce && $rose(coil_a_ground_short_flag)) |-> $past(retry_reg[0]) == SHORT_RETRIES)
		else $error("short confirmed before three retries");
	chk_short_latch: assert property (@(posedge clk) disable iff (rst) // see RL13
		(coil_b_ground_short_flag && driver_enable) |=> coil_b_ground_short_flag)
		else $error("short flag cleared while driver enabled");
	chk_short_own_bridge: assert property (@(posedge clk) disable iff (rst) // see RL12
		(coil_a_ground_short_flag && !coil_b_ground_short_flag && driver_enable
			&& !thermal_shutdown_flag) |-> bridge_enable == 2'b10)
		else $error("short affected the wrong bridge");
	chk_short_b_bridge: assert property (@(posedge clk) disable iff (rst) // see RL12
		(coil_b_ground_short_flag && !coil_a_ground_short_flag && driver_enable
			&& !thermal_shutdown_flag) |-> bridge_enable == 2'b01)
		else $error("short b affected the wrong bridge");
	chk_short_b_retry: assert property (@(posedge clk) disable iff (rst) // see RL11
		(ce && $rose(coil_b_ground_short_flag)) |-> $past(retry_reg[1]) == SHORT_RETRIES)
		else $error("short b confirmed before three retries");
	chk_short_a_latch: assert property (@(posedge clk) disable iff (rst) // see RL13
		(coil_a_ground_short_flag && driver_enable) |=> coil_a_ground_short_flag)
		else $error("short a flag cleared while driver enabled");
	chk_prewarn_follow: assert property (@(posedge clk) disable iff (rst) // see RL9
		ce |=> prewarn_flag == $past(temp_prewarn))
		else $error("prewarning flag did not follow the sensor");
	// a frozen block must not drift even while the sensors change under it
	chk_ce_freeze: assert property (@(posedge clk) disable iff (rst) // see RL14
		!ce |=> ($stable(driver_state_word) && $stable(thermal_shutdown_flag)
			&& $stable(prewarn_flag) && $stable(coil_a_ground_short_flag)))
		else $error("state moved while clock enable was low");
	chk_status_word: assert property (@(posedge clk) disable iff (rst) // see RL14
		driver_state_word == {coil_b_ground_short_flag, coil_a_ground_short_flag,
			prewarn_flag, thermal_shutdown_flag})
		else $error("status word does not match flags");
	cov_short_confirm: cover property (@(posedge clk) disable iff (rst)
		$rose(coil_a_ground_short_flag));
	cov_ot_cycle: cover property (@(posedge clk) disable iff (rst)
		$rose(thermal_shutdown_flag) ##[1:1000] $fell(thermal_shutdown_flag));
	cov_short_restart: cover property (@(posedge clk) disable iff (rst)
		$fell(coil_b_ground_short_flag) ##1 bridge_enable[1]);
endmodule : motor_chopper_diag

//--- verif/coil_load.sv
// behavioural coil and bridge model for one motor coil
// assumes the chopper phase outputs of one coil; the bench commands faults
`timescale 1ns/10ps
module coil_load #(
	parameter int ON_LEN = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic phase_on,
	input wire logic phase_fast,
	input wire logic fd_early,
	input wire logic short_cmd,
	output logic on_trip,
	output logic fd_comp,
	output logic short_detect
);
	int on_reg;
	int fast_reg;
	// each coil has its own rise time, so the two choppers drift apart
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			on_reg <= 0;
			fast_reg <= 0;
		end else begin
			on_reg <= phase_on ? on_reg + 1 : 0;
			fast_reg <= phase_fast ? fast_reg + 1 : 0;
		end
	end
	assign on_trip = phase_on && on_reg >= ON_LEN;
	// negative overshoot only when the bench asks for it
	assign fd_comp = phase_fast && fd_early && fast_reg >= 4;
	// level hit every clock while commanded, as a real short would be
	assign short_detect = short_cmd;
endmodule : coil_load

//--- verif/constant_off_time_chopper_diagnostics_test.sv
// self-checking bench for the two-coil chopper with thermal and short protection
// assumes coil_load partners stand in for the coils and bridges
`timescale 1ns/10ps
module constant_off_time_chopper_diagnostics_test import chop_pkg::*;;
	localparam int SL = int'(SLOW_UNIT) + int'(SLOW_BASE);
	logic clk = 1'b0, rst = 1'b1, driver_enable = 1'b0, chopper_select = 1'b0;
	logic fullstep_mode = 1'b0, speed_ctrl_mode = 1'b0, fast_decay_msb = 1'b0;
	logic fd_comp_disable = 1'b1, random_off_time = 1'b0, temp_prewarn = 1'b0;
	logic temp_shutdown = 1'b0, ce = 1'b1;
	logic [2:0] fast_decay_low_bits = 3'h0;
	logic [3:0] sine_offset_field = 4'h3, slow_decay_time = 4'h0;
	logic [1:0] fd_early = 2'h0, short_cmd = 2'h0;
	logic [7:0] coil_a_target = 8'h00, coil_b_target = 8'h00;
	logic [1:0] coil_on_trip, coil_fd_comp, coil_short_detect, coil_phase_on, coil_phase_fast;
	logic [1:0] coil_phase_slow, bridge_enable;
	logic const_off_active, prewarn_flag, thermal_shutdown_flag;
	logic coil_a_ground_short_flag, coil_b_ground_short_flag;
	logic [7:0] coil_a_target_out, coil_b_target_out;
	logic [3:0] driver_state_word;
	logic [31:0] meas = 32'h0;
	int miscompares = 0;
	int n_checks = 0;
	typedef struct {int id; logic [31:0] v;} note_t;
	note_t q[$];
	note_t nt;
	event look;
	string nm[9] = '{"measure", "tgt_a", "tgt_b", "const_off", "bridges", "thermal", "word",
		"shorts", "prewarn"};
	initial begin
		forever #2.5 clk = ~clk;
	end
	motor_chopper_diag i_motor_chopper_diag (.clk, .rst, .ce, .driver_enable, .chopper_select,
		.fullstep_mode, .speed_ctrl_mode, .fast_decay_msb, .fast_decay_low_bits, .sine_offset_field,
		.slow_decay_time, .fd_comp_disable, .random_off_time, .coil_on_trip, .coil_fd_comp,
		.coil_short_detect, .coil_a_target, .coil_b_target, .temp_prewarn, .temp_shutdown,
		.const_off_active, .coil_phase_on, .coil_phase_fast, .coil_phase_slow, .coil_a_target_out,
		.coil_b_target_out, .bridge_enable, .prewarn_flag, .thermal_shutdown_flag,
		.coil_a_ground_short_flag, .coil_b_ground_short_flag, .driver_state_word);
	for (genvar g = 0; g < 2; g++) begin : g_coil
		coil_load #(.ON_LEN(8 + 3 * g)) i_coil_load (.clk, .rst, .phase_on(coil_phase_on[g]),
			.phase_fast(coil_phase_fast[g]), .fd_early(fd_early[g]), .short_cmd(short_cmd[g]),
			.on_trip(coil_on_trip[g]), .fd_comp(coil_fd_comp[g]), .short_detect(coil_short_detect[g]));
	end
	function automatic logic [31:0] seen(input int id);
		case (id)
			0: return meas;
			1: return {24'h0, coil_a_target_out};
			2: return {24'h0, coil_b_target_out};
			3: return {31'h0, const_off_active};
			4: return {30'h0, bridge_enable};
			5: return {31'h0, thermal_shutdown_flag};
			6: return {28'h0, driver_state_word};
			8: return {31'h0, prewarn_flag};
			default: return {30'h0, coil_b_ground_short_flag, coil_a_ground_short_flag};
		endcase
	endfunction : seen
	function automatic logic [7:0] offs(input logic [7:0] t, input logic [3:0] f);
		int s;
		s = int'(t) + int'(f) - int'(OFFSET_ZERO);
		return (s < 0) ? 8'h00 : (s > 255) ? 8'hFF : s[7:0];
	endfunction : offs
	function automatic logic phb(input int b);
		logic [2:0] p;
		p = {coil_phase_on[0], coil_phase_fast[0], coil_phase_slow[0]};
		return p[b];
	endfunction : phb
	task automatic end_sim();
		if (miscompares == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input int id, input logic [31:0] v);
		q.push_back('{id, v});
		->look;
		#0.1;
	endtask : chk
	always @(look) begin
		while (q.size() > 0) begin
			nt = q.pop_front();
			n_checks++;
			if (seen(nt.id) !== nt.v) begin
				miscompares++;
				$display("BAD %s exp %0h got %0h", nm[nt.id], nt.v, seen(nt.id));
			end
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	// bounded wait on one coil A phase: bit 2 on, 1 fast, 0 slow
	task automatic wait_ph(input int b, input logic v);
		int i;
		for (i = 0; i < 2000 && phb(b) !== v; i++) begin
			@(negedge clk);
		end
		if (i == 2000) begin
			miscompares++;
			$display("BAD phase exp %0h got %0h", v, phb(b));
			end_sim();
		end
	endtask : wait_ph
	task automatic len_ph(input int b);
		int n;
		wait_ph(b, 1'b1);
		for (n = 0; n < 2000 && phb(b) === 1'b1; n++) begin
			@(negedge clk);
		end
		meas = n;
		if (n == 2000) begin
			miscompares++;
			$display("BAD phase_len exp %0d got %0d", 1999, n);
			end_sim();
		end
	endtask : len_ph
	initial begin
		int n;
		logic [7:0] tt[3];
		n = $urandom(57315);
		tt = '{8'h01, 8'hFE, 8'h00};
		tt[2] = 8'($urandom);
		repeat (16) @(posedge clk);
		@(negedge clk);
		chk(6, 32'h0);
		rst = 1'b0;
		driver_enable = 1'b1;
		chopper_select = 1'b1;
		slow_decay_time = 4'h1;
		{fast_decay_msb, fast_decay_low_bits} = 4'hF;
		len_ph(1);
		chk(0, 15 * FAST_UNIT);
		// coil b trips three clocks later, so it is still in fast decay here
		meas = {30'h0, coil_phase_fast};
		chk(0, 32'h2);
		len_ph(0);
		chk(0, SL);
		{fast_decay_msb, fast_decay_low_bits} = 4'h0;
		wait_ph(2, 1'b1);
		wait_ph(2, 1'b0);
		meas = {29'h0, phb(2), phb(1), phb(0)};
		chk(0, 32'h1);
		{fast_decay_msb, fast_decay_low_bits} = 4'h1;
		random_off_time = 1'b1;
		wait_ph(2, 1'b1);
		n = 0;
		repeat (6) begin
			len_ph(0);
			n += int'(meas > SL);
			meas = 32'(meas >= SL && meas <= SL + 7);
			chk(0, 32'h1);
		end
		// six draws all at zero spread would mean the modulation never acts
		meas = 32'(n > 0);
		chk(0, 32'h1);
		random_off_time = 1'b0;
		fd_comp_disable = 1'b0;
		fd_early = 2'h3;
		{fast_decay_msb, fast_decay_low_bits} = 4'hF;
		wait_ph(2, 1'b1);
		len_ph(1);
		meas = 32'(meas < 10);
		chk(0, 32'h1);
		fd_comp_disable = 1'b1;
		len_ph(1);
		chk(0, 15 * FAST_UNIT);
		fd_early = 2'h0;
		foreach (tt[i]) begin
			coil_a_target = tt[i];
			coil_b_target = ~tt[i];
			for (int f = 0; f < 16; f++) begin
				sine_offset_field = 4'(f);
				cyc(1);
				chk(1, offs(coil_a_target, 4'(f)));
				chk(2, offs(coil_b_target, 4'(f)));
			end
		end
		chopper_select = 1'b0;
		cyc(1);
		chk(3, 32'h0);
		chk(1, coil_a_target);
		fullstep_mode = 1'b1;
		speed_ctrl_mode = 1'b1;
		cyc(1);
		chk(3, 32'h1);
		chk(1, offs(coil_a_target, 4'hF));
		// clock enable low must freeze every flag even with both sensors hot
		ce = 1'b0;
		temp_prewarn = 1'b1;
		temp_shutdown = 1'b1;
		cyc(2);
		chk(5, 32'h0);
		chk(8, 32'h0);
		chk(6, 32'h0);
		ce = 1'b1;
		cyc(1);
		temp_shutdown = 1'b0;
		chk(5, 32'h1);
		chk(8, 32'h1);
		chk(4, 32'h0);
		chk(6, 32'h3);
		cyc(20);
		chk(5, 32'h1);
		temp_prewarn = 1'b0;
		cyc(1);
		chk(5, 32'h0);
		chk(8, 32'h0);
		chk(4, 32'h3);
		for (int c = 0; c < 2; c++) begin
			short_cmd[c] = 1'b1;
			cyc(3);
			chk(7, 32'h0);
			cyc(2);
			chk(7, 32'h1 << c);
			chk(4, 32'h3 & ~(32'h1 << c));
			chk(6, 32'h4 << c);
			short_cmd[c] = 1'b0;
			cyc(5);
			chk(7, 32'h1 << c);
			driver_enable = 1'b0;
			cyc(1);
			chk(7, 32'h0);
			driver_enable = 1'b1;
			cyc(1);
			chk(4, 32'h3);
		end
		end_sim();
	end
endmodule : constant_off_time_chopper_diagnostics_test
